// file: dv/ccrb_core_model.sv
// behavioural cpu core driving the core side of the bank
`timescale 1ns/1ps
`default_nettype none
module ccrb_core_model
(
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // bench control: cmd is {stack, sleep, flash, data}
  input  wire logic                   run,
  input  wire logic [3:0]             cmd,
  // core events
  output logic                        instr_cycle,
  output logic                        data_write,
  output logic                        flash_instr,
  output logic                        sleep_instr,
  output ccrb_pkg::ccrb_flag_update_s flag_update,
  output logic                        stack_load,
  output logic [15:0]                 stack_value,
  output ccrb_pkg::ccrb_pointers_s    pointers
);
  integer seed = 32'hFF78F6D5;
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      {instr_cycle, stack_load, sleep_instr, flash_instr, data_write} <= 5'h00;
      flag_update <= '0;
      stack_value <= 16'h0000;
      pointers <= '0;
    end
    else
    begin
      instr_cycle <= run && ($random(seed) & 1);
      // closing writes and instructions come only on command
      {stack_load, sleep_instr, flash_instr, data_write} <= cmd;
      if (cmd[3])
        stack_value <= 16'($random(seed));
      // global enable stays with software, so bit 7 is never touched here
      flag_update <= run ? {8'h7F & 8'($random(seed)), 8'($random(seed))} : 16'h0000;
      if (run)
        pointers <= {$random(seed), $random(seed)};
    end
  end
endmodule
`default_nettype wire

// file: dv/ccrb_top_sva.sv
// port assertions for the cpu control register bank
`timescale 1ns/1ps
`default_nettype none
module ccrb_top_sva
(
  // clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  // core side
  input wire logic        instr_cycle,
  input wire logic [7:0]  cpu_flags,
  input wire logic        bit_copy,
  input wire logic        irq_allowed,
  input wire logic        protected_io_mode,
  input wire logic        self_program_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ==========================================
  // helpers
  wire        wr_done  = psel && penable && pready && pwrite && pstrb[0];
  wire        guard_rd = pready && !pwrite && paddr == 8'h10;
  wire        win_open = protected_io_mode || self_program_mode;
  logic [2:0] win_cnt;
  // only valid while no signature is rewritten into an open window
  always_ff @(posedge clock or posedge reset)
    if (reset)
      win_cnt <= 3'h0;
    else
      win_cnt <= win_open ? win_cnt + {2'h0, instr_cycle} : 3'h0;
  // ==========================================
  // assertions
  ready_after_access_a: assert property ($rose(psel && penable) |=> pready)
    else $error("no answer one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  guard_zero_a: assert property (guard_rd |-> prdata[7:2] == 6'h00)
    else $error("guard upper bits not zero");
  guard_bits_a: assert property (guard_rd |-> prdata[1:0] == $past({self_program_mode, protected_io_mode}))
    else $error("guard status bits wrong");
  io_opens_a: assert property (wr_done && paddr == 8'h10 && pwdata[7:0] == 8'hD8 |=> protected_io_mode && !self_program_mode)
    else $error("io signature did not open");
  prog_opens_a: assert property (wr_done && paddr == 8'h10 && pwdata[7:0] == 8'h9D |=> self_program_mode && !protected_io_mode)
    else $error("program signature did not open");
  window_len_a: assert property (win_open |-> win_cnt < 3'h4)
    else $error("window open too long");
  window_irq_a: assert property (win_open |-> !irq_allowed)
    else $error("irq allowed in window");
  stack_hold_a: assert property (wr_done && paddr == 8'h34 |=> !irq_allowed)
    else $error("irq allowed after stack low write");
  global_off_a: assert property (!cpu_flags[7] |-> !irq_allowed)
    else $error("irq allowed with global enable clear");
  sign_xor_a: assert property (cpu_flags[4] == (cpu_flags[2] ^ cpu_flags[3]))
    else $error("sign bit wrong");
  bit_copy_a: assert property (bit_copy == cpu_flags[6])
    else $error("bit copy differs from flag");
endmodule
bind ccrb_top ccrb_top_sva chk (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
  .instr_cycle, .cpu_flags, .bit_copy, .irq_allowed, .protected_io_mode, .self_program_mode);
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench of the cpu control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0]  DM = 8'h0F;
  localparam logic [7:0]  PM = 8'h30;
  localparam logic [7:0]  JM = 8'h01;
  localparam logic [15:0] SM = 16'h3FFF;
  localparam logic [15:0] ST = 16'h2FFF;
  // ==========================================
  // signals
  logic                        clock, reset, psel, penable, pwrite, pready, pslverr, run, err;
  logic                        instr_cycle, data_write, flash_instr, sleep_instr, stack_load;
  logic                        bit_copy, irq_allowed, protected_io_mode, self_program_mode;
  logic [7:0]                  paddr, cpu_flags, rd, v;
  logic [7:0]                  pg [5];
  logic [31:0]                 pwdata, prdata;
  logic [3:0]                  pstrb, cmd;
  logic [15:0]                 stack_value, stack_pointer;
  ccrb_pkg::ccrb_flag_update_s flag_update;
  ccrb_pkg::ccrb_pointers_s    pointers;
  ccrb_pkg::ccrb_ext_addr_s    ext_addr;
  integer                      errors = 0;
  integer                      cmp_count = 0;
  integer                      seed = 32'hFF78F6D5;
  // ==========================================
  // instances
  ccrb_top #(.DATA_PAGE_MASK(DM), .PROG_PAGE_MASK(PM), .JUMP_MASK(JM), .STACK_MASK(SM), .SRAM_TOP(ST)) uut
    (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
     .instr_cycle, .data_write, .flash_instr, .sleep_instr, .flag_update, .stack_load, .stack_value,
     .pointers, .ext_addr, .stack_pointer, .cpu_flags, .bit_copy, .irq_allowed, .protected_io_mode,
     .self_program_mode);
  ccrb_core_model core (.clock, .reset, .run, .cmd, .instr_cycle, .data_write, .flash_instr, .sleep_instr,
    .flag_update, .stack_load, .stack_value, .pointers);
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
      errors++;
    if (got !== exp)
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'($random(seed)), d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    // pready and prdata read at the edge, before that edge's updates land
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    chk(n < 16, 1, "apb answer");
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic close_out;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [7:0] page_mask(input int i);
    return (i == 4) ? JM : (i == 3) ? (DM | PM) : DM;
  endfunction
  function automatic logic [7:0] flag_exp(input logic [7:0] f);
    return {f[7:5], f[2] ^ f[3], f[3:0]};
  endfunction
  // ==========================================
  // scenarios
  initial
  begin
    {reset, psel, penable, pwrite, run, paddr, pwdata, cmd} = {5'h10, 8'h00, 32'h0, 4'h0};
    pstrb = 4'hF;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    apb(0, 8'h34, 8'h00);
    chk(rd, ST[7:0], "stack low reset");
    apb(0, 8'h38, 8'h00);
    chk(rd, ST[15:8], "stack high reset");
    chk(stack_pointer, ST, "stack pointer reset");
    run <= 1'b1;
    repeat (8) @(posedge clock);
    run <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      v = 8'($random(seed));
      apb(1, 8'h20 + 8'(4 * i), v);
      apb(0, 8'h20 + 8'(4 * i), 8'h00);
      pg[i] = v & page_mask(i);
      chk(rd, pg[i], "page readback");
    end
    repeat (2) @(negedge clock);
    chk(ext_addr.direct_addr, {pg[0], pointers.operand}, "direct address");
    chk(ext_addr.x_addr, {pg[1], pointers.x_ptr}, "x address");
    chk(ext_addr.y_addr, {pg[2], pointers.y_ptr}, "y address");
    chk(ext_addr.z_data_addr, {pg[3] & DM, pointers.z_ptr}, "z data address");
    chk(ext_addr.flash_addr, {pg[3] & PM, pointers.z_ptr}, "flash address");
    chk(ext_addr.jump_addr, {pg[4], pointers.z_ptr}, "jump address");
    apb(0, 8'h14, 8'h00);
    chk({err, rd}, 9'h100, "reserved read");
    apb(0, 8'h21, 8'h00);
    chk({err, rd}, 9'h100, "unaligned read");
    pstrb <= 4'hE;
    apb(1, 8'h20, ~pg[0]);
    pstrb <= 4'hF;
    apb(0, 8'h20, 8'h00);
    chk({err, rd}, {1'b0, pg[0]}, "write without strobe ignored");
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'h0C : (i == 1) ? 8'h14 : 8'($random(seed));
      apb(1, 8'h3C, v);
      apb(0, 8'h3C, 8'h00);
      chk(rd, flag_exp(v), "flags readback");
      chk({bit_copy, cpu_flags}, {v[6], flag_exp(v)}, "flag outputs");
      chk(irq_allowed, v[7], "global enable");
    end
    apb(1, 8'h3C, 8'h80);
    for (int i = 0; i < 2; i++)
    begin
      apb(1, 8'h10, i ? 8'h9D : 8'hD8);
      apb(0, 8'h10, 8'h00);
      chk(rd, i ? 8'h02 : 8'h01, "guard open");
      chk(irq_allowed, 0, "irq held in window");
      run <= 1'b1;
      repeat (40) @(posedge clock);
      run <= 1'b0;
      apb(0, 8'h10, 8'h00);
      chk(rd, 0, "guard closed by count");
      chk(irq_allowed, 1, "irq resumed");
    end
    for (int i = 0; i < 5; i++)
    begin
      apb(1, 8'h10, (i < 3) ? 8'hD8 : 8'h9D);
      cmd <= (i == 4) ? 4'h4 : 4'(1 << (i % 3));
      @(posedge clock);
      cmd <= 4'h0;
      apb(0, 8'h10, 8'h00);
      chk(rd, 0, "guard killed");
    end
    apb(1, 8'h10, 8'h55);
    apb(0, 8'h10, 8'h00);
    chk({irq_allowed, rd}, 9'h100, "no signature");
    v = 8'($random(seed));
    apb(1, 8'h34, v);
    @(negedge clock);
    chk(irq_allowed, 0, "hold after low write");
    apb(1, 8'h38, 8'hD5);
    @(negedge clock);
    chk(irq_allowed, 1, "hold ended by high write");
    apb(0, 8'h38, 8'h00);
    chk(rd, 8'h15, "stack high bits");
    chk(stack_pointer, {8'hD5, v} & SM, "stack pointer written");
    cmd <= 4'h8;
    @(posedge clock);
    cmd <= 4'h0;
    repeat (3) @(negedge clock);
    chk(stack_pointer, stack_value & SM, "stack load from core");
    apb(1, 8'h34, v);
    run <= 1'b1;
    repeat (20) @(posedge clock);
    @(negedge clock);
    chk(irq_allowed, 1, "hold ended by count");
    for (int i = 0; i < 30; i++)
      apb(1'($random(seed)), 8'h20 + 8'(4 * ($unsigned($random(seed)) % 8)), 8'($random(seed)));
    run <= 1'b0;
    close_out();
  end
  initial
  begin
    #100000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire

// file: hdl/ccrb_consts.svh
// constants of the cpu control register bank
`ifndef CCRB_CONSTS_SVH
`define CCRB_CONSTS_SVH

// register indices; byte address is four times the index
`define CCRB_IDX_CHANGE_GUARD  6'h04
`define CCRB_IDX_DIRECT_PAGE   6'h08
`define CCRB_IDX_X_PAGE        6'h09
`define CCRB_IDX_Y_PAGE        6'h0A
`define CCRB_IDX_Z_PAGE        6'h0B
`define CCRB_IDX_JUMP_EXT      6'h0C
`define CCRB_IDX_STACK_LOW     6'h0D
`define CCRB_IDX_STACK_HIGH    6'h0E
`define CCRB_IDX_CPU_FLAGS     6'h0F

// change guard signatures and status bits
`define CCRB_SIG_SELF_PROGRAM  8'h9D
`define CCRB_SIG_PROTECTED_IO  8'hD8
`define CCRB_GUARD_IO_BIT      0
`define CCRB_GUARD_PRG_BIT     1

// flag bit positions
`define CCRB_FLAG_I            7
`define CCRB_FLAG_T            6
`define CCRB_FLAG_H            5
`define CCRB_FLAG_S            4
`define CCRB_FLAG_V            3
`define CCRB_FLAG_N            2
`define CCRB_FLAG_Z            1
`define CCRB_FLAG_C            0

// timing, in cpu instruction cycles
`define CCRB_GUARD_CYCLES      3'h4
`define CCRB_STACK_HOLD_CYCLES 3'h4

// reset values
`define CCRB_RST_PAGE          8'h00
`define CCRB_RST_FLAGS         8'h00

`endif

// file: hdl/ccrb_pkg.sv
// types of the cpu control register bank
package ccrb_pkg;

  // masked flag update from the core: sign bit is derived, never taken
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] value;
  } ccrb_flag_update_s;

  // pointer values from the core register file
  typedef struct packed {
    logic [15:0] x_ptr;
    logic [15:0] y_ptr;
    logic [15:0] z_ptr;
    logic [15:0] operand;
  } ccrb_pointers_s;

  // extended 24-bit addresses handed back to the core
  typedef struct packed {
    logic [23:0] direct_addr;
    logic [23:0] x_addr;
    logic [23:0] y_addr;
    logic [23:0] z_data_addr;
    logic [23:0] flash_addr;
    logic [23:0] jump_addr;
  } ccrb_ext_addr_s;

  typedef enum logic [1:0] {
    CCRB_GUARD_CLOSED,
    CCRB_GUARD_IO,
    CCRB_GUARD_PRG
  } ccrb_guard_e;

endpackage

// file: hdl/ccrb_top.sv
// cpu control register bank with apb slave
//
// Behaviour
// - 0x9D opens self-program window, 0xD8 opens protected io window.
// - open window closes by itself after four instruction cycles.
// - interrupts are held off while a guard window is open.
// - guard bit 0 reads one while the io window is open.
// - guard bit 1 reads one while the self-program window is open.
// - guard bits 7 to 2 always read zero.
// - direct page forms top byte of 24-bit direct address.
// - x page forms top byte of 24-bit x address.
// - y page forms top byte of 24-bit y address.
// - page and jump bits not implemented read as zero.
// - z page extends z for extended flash read and self-programming.
// - jump extension forms top byte of 24-bit jump/call target.
// - jump extension absent when program memory is small.
// - reset loads stack pointer with highest internal sram address.
// - stack low write holds interrupts until high write or four instructions.
// - only implemented stack pointer bits exist; others read zero.
// - global enable bit blocks all interrupts; not cleared on entry.
// - bit 6 is bit_store destination and bit_load source.
// - sign bit always equals negative xor overflow.
// - bit 5 half carry, bit 3 overflow.
// - bit 2 negative, bit 1 zero, bit 0 carry.
`include "ccrb_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ccrb_top
#(
  parameter logic [7:0]  DATA_PAGE_MASK = 8'hFF,
  parameter logic [7:0]  PROG_PAGE_MASK = 8'hFF,
  parameter logic [7:0]  JUMP_MASK      = 8'hFF,
  parameter logic [15:0] STACK_MASK     = 16'hFFFF,
  parameter logic [15:0] SRAM_TOP       = 16'h3FFF
)
(
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  // core events
  input  wire logic                       instr_cycle,
  input  wire logic                       data_write,
  input  wire logic                       flash_instr,
  input  wire logic                       sleep_instr,
  input  wire ccrb_pkg::ccrb_flag_update_s flag_update,
  input  wire logic                       stack_load,
  input  wire logic [15:0]                stack_value,
  input  wire ccrb_pkg::ccrb_pointers_s   pointers,
  // core results
  output ccrb_pkg::ccrb_ext_addr_s        ext_addr,
  output logic [15:0]                     stack_pointer,
  output logic [7:0]                      cpu_flags,
  output logic                            bit_copy,
  output logic                            irq_allowed,
  output logic                            protected_io_mode,
  output logic                            self_program_mode
);

  // =========================================================
  // apb decode
  // =========================================================
  wire logic [5:0] reg_index = paddr[7:2];
  wire logic       access    = psel & penable & pready;
  wire logic       wr        = access & pwrite & pstrb[0];
  wire logic       aligned   = (paddr[1:0] == 2'b00);
  wire logic       hit_guard = aligned & (reg_index == `CCRB_IDX_CHANGE_GUARD);
  wire logic       hit_dpage = aligned & (reg_index == `CCRB_IDX_DIRECT_PAGE);
  wire logic       hit_xpage = aligned & (reg_index == `CCRB_IDX_X_PAGE);
  wire logic       hit_ypage = aligned & (reg_index == `CCRB_IDX_Y_PAGE);
  wire logic       hit_zpage = aligned & (reg_index == `CCRB_IDX_Z_PAGE);
  wire logic       hit_jump  = aligned & (reg_index == `CCRB_IDX_JUMP_EXT);
  wire logic       hit_slo   = aligned & (reg_index == `CCRB_IDX_STACK_LOW);
  wire logic       hit_shi   = aligned & (reg_index == `CCRB_IDX_STACK_HIGH);
  wire logic       hit_flags = aligned & (reg_index == `CCRB_IDX_CPU_FLAGS);
  wire logic       mapped    = hit_guard | hit_dpage | hit_xpage | hit_ypage | hit_zpage
                             | hit_jump | hit_slo | hit_shi | hit_flags;
  wire logic [7:0] wbyte     = pwdata[7:0];

  // =========================================================
  // state
  // =========================================================
  ccrb_pkg::ccrb_guard_e guard_mode;
  logic [2:0]            guard_count;
  logic [2:0]            stack_hold;
  logic [7:0]            direct_page;
  logic [7:0]            x_page;
  logic [7:0]            y_page;
  logic [7:0]            z_page;
  logic [7:0]            jump_extension;
  logic [15:0]           stack_reg;
  logic [7:0]            flag_reg;
  logic                  stack_init;

  // =========================================================
  // change guard
  // =========================================================
  // signature match
  wire logic guard_wr   = wr & hit_guard;
  wire logic sig_prg    = guard_wr & (wbyte == `CCRB_SIG_SELF_PROGRAM);
  wire logic sig_io     = guard_wr & (wbyte == `CCRB_SIG_PROTECTED_IO);
  // any mapped register write other than the guard, and any core data write, flash or sleep instruction, ends the io window early
  wire logic io_kill    = data_write | flash_instr | sleep_instr | (wr & ~hit_guard & mapped);
  wire logic prg_kill   = data_write | sleep_instr;
  wire logic count_end  = instr_cycle & (guard_count == 3'h1);

  ccrb_pkg::ccrb_guard_e next_guard_mode;
  logic [2:0]            next_guard_count;

  always_comb
  begin
    next_guard_mode  = guard_mode;
    next_guard_count = guard_count;
    if (sig_prg)
    begin
      next_guard_mode  = ccrb_pkg::CCRB_GUARD_PRG;
      next_guard_count = `CCRB_GUARD_CYCLES;
    end
    else if (sig_io)
    begin
      next_guard_mode  = ccrb_pkg::CCRB_GUARD_IO;
      next_guard_count = `CCRB_GUARD_CYCLES;
    end
    else
    begin
      case (guard_mode)
        ccrb_pkg::CCRB_GUARD_IO:
        begin
          if (io_kill | count_end)
          begin
            next_guard_mode  = ccrb_pkg::CCRB_GUARD_CLOSED;
            next_guard_count = 3'h0;
          end
          else if (instr_cycle)
          begin
            next_guard_count = guard_count - 3'h1;
          end
        end
        ccrb_pkg::CCRB_GUARD_PRG:
        begin
          if (prg_kill | count_end)
          begin
            next_guard_mode  = ccrb_pkg::CCRB_GUARD_CLOSED;
            next_guard_count = 3'h0;
          end
          else if (instr_cycle)
          begin
            next_guard_count = guard_count - 3'h1;
          end
        end
        default:
        begin
          next_guard_mode  = ccrb_pkg::CCRB_GUARD_CLOSED;
          next_guard_count = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      guard_mode  <= ccrb_pkg::CCRB_GUARD_CLOSED;
      guard_count <= 3'h0;
    end
    else
    begin
      guard_mode  <= next_guard_mode;
      guard_count <= next_guard_count;
    end
  end

  // io bit, program bit, upper bits zero
  wire logic [7:0] guard_read = {6'h00,
                                 guard_mode == ccrb_pkg::CCRB_GUARD_PRG,
                                 guard_mode == ccrb_pkg::CCRB_GUARD_IO};

  // =========================================================
  // page and jump registers
  // =========================================================
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      direct_page    <= `CCRB_RST_PAGE;
      x_page         <= `CCRB_RST_PAGE;
      y_page         <= `CCRB_RST_PAGE;
      z_page         <= `CCRB_RST_PAGE;
      jump_extension <= `CCRB_RST_PAGE;
    end
    else
    begin
      if (wr & hit_dpage)
        direct_page <= wbyte & DATA_PAGE_MASK;
      if (wr & hit_xpage)
        x_page <= wbyte & DATA_PAGE_MASK;
      if (wr & hit_ypage)
        y_page <= wbyte & DATA_PAGE_MASK;
      if (wr & hit_zpage)
        z_page <= wbyte & (DATA_PAGE_MASK | PROG_PAGE_MASK);
      if (wr & hit_jump)
        jump_extension <= wbyte & JUMP_MASK;
    end
  end

  // =========================================================
  // stack pointer
  // =========================================================
  // low byte write starts the interrupt hold
  wire logic slo_wr = wr & hit_slo;
  wire logic shi_wr = wr & hit_shi;
  logic [2:0] next_stack_hold;

  always_comb
  begin
    next_stack_hold = stack_hold;
    if (slo_wr)
      next_stack_hold = `CCRB_STACK_HOLD_CYCLES;
    else if (shi_wr)
      next_stack_hold = 3'h0;
    else if (instr_cycle & (stack_hold != 3'h0))
      next_stack_hold = stack_hold - 3'h1;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      stack_reg  <= 16'h0000;
      stack_init <= 1'b1;
      stack_hold <= 3'h0;
    end
    else
    begin
      stack_hold <= next_stack_hold;
      stack_init <= 1'b0;
      if (stack_init)
        stack_reg <= SRAM_TOP & STACK_MASK;
      else if (stack_load)
        stack_reg <= stack_value & STACK_MASK;
      else if (slo_wr)
        stack_reg[7:0] <= wbyte & STACK_MASK[7:0];
      else if (shi_wr)
        stack_reg[15:8] <= wbyte & STACK_MASK[15:8];
    end
  end

  // =========================================================
  // cpu flags
  // =========================================================
  // sign is not stored; it is rebuilt from n and v on every read
  wire logic [7:0] flag_src = (wr & hit_flags) ? wbyte : flag_reg;
  wire logic [7:0] upd_mask = flag_update.mask;
  wire logic [7:0] flag_new = (flag_src & ~upd_mask) | (flag_update.value & upd_mask);
  wire logic       sign_bit = flag_reg[`CCRB_FLAG_N] ^ flag_reg[`CCRB_FLAG_V];
  wire logic [7:0] flag_read = {flag_reg[7:5], sign_bit, flag_reg[3:0]};
  wire logic       next_sign = flag_new[`CCRB_FLAG_N] ^ flag_new[`CCRB_FLAG_V];

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      flag_reg <= `CCRB_RST_FLAGS;
    else
      flag_reg <= {flag_new[7:5], 1'b0, flag_new[3:0]};
  end

  // =========================================================
  // core outputs
  // =========================================================
  // interrupt gate from the coming state
  wire logic next_irq = flag_new[`CCRB_FLAG_I]
                      & (next_guard_mode == ccrb_pkg::CCRB_GUARD_CLOSED)
                      & (next_stack_hold == 3'h0);
  ccrb_pkg::ccrb_ext_addr_s next_ext;

  always_comb
  begin
    next_ext.direct_addr = {direct_page, pointers.operand};
    next_ext.x_addr      = {x_page, pointers.x_ptr};
    next_ext.y_addr      = {y_page, pointers.y_ptr};
    // z page join for data and flash
    next_ext.z_data_addr = {z_page & DATA_PAGE_MASK, pointers.z_ptr};
    next_ext.flash_addr  = {z_page & PROG_PAGE_MASK, pointers.z_ptr};
    next_ext.jump_addr   = {jump_extension, pointers.z_ptr};
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ext_addr          <= '0;
      stack_pointer     <= 16'h0000;
      cpu_flags         <= `CCRB_RST_FLAGS;
      bit_copy          <= 1'b0;
      irq_allowed       <= 1'b0;
      protected_io_mode <= 1'b0;
      self_program_mode <= 1'b0;
    end
    else
    begin
      ext_addr          <= next_ext;
      stack_pointer     <= stack_reg;
      cpu_flags         <= {flag_new[7:5], next_sign, flag_new[3:0]};
      bit_copy          <= flag_new[`CCRB_FLAG_T];
      irq_allowed       <= next_irq;
      protected_io_mode <= (next_guard_mode == ccrb_pkg::CCRB_GUARD_IO);
      self_program_mode <= (next_guard_mode == ccrb_pkg::CCRB_GUARD_PRG);
    end
  end

  // =========================================================
  // apb read and answer
  // =========================================================
  logic [7:0] read_byte;

  always_comb
  begin
    read_byte = 8'h00;
    if (hit_guard)
      read_byte = guard_read;
    else if (hit_dpage)
      read_byte = direct_page;
    else if (hit_xpage)
      read_byte = x_page;
    else if (hit_ypage)
      read_byte = y_page;
    else if (hit_zpage)
      read_byte = z_page;
    else if (hit_jump)
      read_byte = jump_extension;
    else if (hit_slo)
      read_byte = stack_reg[7:0];
    else if (hit_shi)
      read_byte = stack_reg[15:8];
    else if (hit_flags)
      read_byte = flag_read;
  end

  // one wait state keeps every bus output on a flip-flop
  wire logic answer_now = psel & penable & ~pready;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= answer_now;
      prdata  <= (answer_now & ~pwrite) ? {24'h00_0000, read_byte} : 32'h0000_0000;
      pslverr <= answer_now & ~mapped;
    end
  end

endmodule

`default_nettype wire
